/* design/serial_config_port_regs.svh */
`ifndef SERIAL_CONFIG_PORT_REGS_SVH
`define SERIAL_CONFIG_PORT_REGS_SVH
`define INSTR_BITS 5'd16
`define INSTR_LAST 4'hf
`define BYTE_LAST 3'h7
`define LEN_STREAM 2'h3
`define CFG_ADDR 8'h00
`define UNBUF_ADDR_A 8'h04
`define UNBUF_ADDR_B 8'h05
`define XFER_ADDR 8'hff
`define XFER_GO_BIT 0
`define LSB_FIRST_BIT 6
`define REG_RESET 8'h00
`define STRAP_WAIT 3'h6
`define REG_COUNT 256
`endif

/* design/serial_config_port_pkg.sv */
package serial_config_port_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_INSTR = 2'b01,
        ST_DATA = 2'b10
    } frame_state_t;

    typedef struct packed {
        logic is_read;
        logic xfer_len_hi;
        logic xfer_len_lo;
        logic [12:0] addr;
    } instr_t;
endpackage : serial_config_port_pkg

/* design/serial_config_port.sv */
`timescale 1ns/1ps
`include "serial_config_port_regs.svh"
module serial_config_port (
    input wire logic ref_clk_in, // 125 MHz system clock
    input wire logic rst_in, // async reset, active high
    input wire logic sclk_in, // serial clock pin
    input wire logic cs_n_in, // chip select pin, active low
    input wire logic sdio_in, // data pin, input side
    input wire logic two_wire_in, // 1: chip select is tied low
    input wire logic [7:0] cfg_addr_in, // applied register lookup address
    output logic sdio_out, // data pin, output side
    output logic sdio_oe_out, // data pin driven by device
    output logic secondary_mode_out, // pins in strapped secondary role
    output logic alt_sclk_out, // clock pin level in secondary role
    output logic alt_sdio_out, // data pin level in secondary role
    output logic lsb_first_out, // current bit order
    output logic frame_active_out, // frame in progress
    output logic xfer_done_out, // one-cycle pulse: buffered registers applied
    output logic [7:0] cfg_data_out // applied value at cfg_addr_in
);
    // ==========================================
    // pin synchronisers
    logic [2:0] sclk_sync;
    logic [2:0] cs_sync;
    logic [2:0] sdio_sync;
    logic sclk_st;
    logic cs_st;
    logic sdio_st;

    // a change counts only once stages two and three agree
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sclk_sync <= 3'h0;
            cs_sync <= 3'h7;
            sdio_sync <= 3'h0;
            sclk_st <= 1'b0;
            cs_st <= 1'b1;
            sdio_st <= 1'b0;
        end else begin
            sclk_sync <= {sclk_sync[1:0], sclk_in};
            cs_sync <= {cs_sync[1:0], cs_n_in};
            sdio_sync <= {sdio_sync[1:0], sdio_in};
            if (sclk_sync[1] == sclk_sync[2]) begin
                sclk_st <= sclk_sync[2];
            end
            if (cs_sync[1] == cs_sync[2]) begin
                cs_st <= cs_sync[2];
            end
            if (sdio_sync[1] == sdio_sync[2]) begin
                sdio_st <= sdio_sync[2];
            end
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_rise;
    logic sdio_bit;
    assign sclk_rise = (sclk_sync[1] == sclk_sync[2]) && sclk_sync[2] && !sclk_st;
    assign sclk_fall = (sclk_sync[1] == sclk_sync[2]) && !sclk_sync[2] && sclk_st;
    assign cs_rise = (cs_sync[1] == cs_sync[2]) && cs_sync[2] && !cs_st;
    // data is settled well before the clock edge, so take stage three without waiting for agreement
    assign sdio_bit = sdio_sync[2];

    // ==========================================
    // strap capture
    logic [2:0] strap_cnt;
    logic strap_done;

    // pin pull-up makes an unconnected select read high at power-up
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            strap_cnt <= 3'h0;
            strap_done <= 1'b0;
            secondary_mode_out <= 1'b0;
        end else if (!strap_done) begin
            strap_cnt <= strap_cnt + 3'h1;
            if (strap_cnt == `STRAP_WAIT) begin
                strap_done <= 1'b1;
                secondary_mode_out <= cs_st && !two_wire_in;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            alt_sclk_out <= 1'b0;
            alt_sdio_out <= 1'b0;
        end else begin
            alt_sclk_out <= secondary_mode_out & sclk_st;
            alt_sdio_out <= secondary_mode_out & sdio_st;
        end
    end

    // ==========================================
    // register storage
    logic [7:0] shadow_mem [0:`REG_COUNT-1];
    logic [7:0] active_mem [0:`REG_COUNT-1];
    logic lsb_first;
    assign lsb_first = active_mem[`CFG_ADDR][`LSB_FIRST_BIT];

    // ==========================================
    // frame engine
    serial_config_port_pkg::frame_state_t state;
    serial_config_port_pkg::instr_t instr;
    logic [15:0] instr_sr;
    logic [3:0] instr_cnt;
    logic [7:0] rx_sr;
    logic [2:0] data_cnt;
    logic [1:0] bytes_left;
    logic streaming;
    logic [7:0] tx_byte;
    logic [12:0] addr;

    function automatic logic [15:0] shift16(input logic [15:0] sr, input logic b, input logic lsb);
        shift16 = lsb ? {b, sr[15:1]} : {sr[14:0], b};
    endfunction : shift16

    function automatic logic [7:0] shift8(input logic [7:0] sr, input logic b, input logic lsb);
        shift8 = lsb ? {b, sr[7:1]} : {sr[6:0], b};
    endfunction : shift8

    function automatic logic [12:0] step_addr(input logic [12:0] a, input logic lsb);
        step_addr = lsb ? a + 13'h1 : a - 13'h1;
    endfunction : step_addr

    logic sel_low;
    logic active_rise;
    logic [15:0] next_instr;
    logic [7:0] next_byte;
    logic byte_done;
    logic wr_fire;
    logic [12:0] next_addr;

    assign sel_low = two_wire_in || !cs_st;
    // no register traffic while deselected or strapped to the secondary role
    assign active_rise = sclk_rise && sel_low && strap_done && !secondary_mode_out;
    assign next_instr = shift16(instr_sr, sdio_bit, lsb_first);
    assign next_byte = shift8(rx_sr, sdio_bit, lsb_first);
    assign byte_done = active_rise && (state == serial_config_port_pkg::ST_DATA) && (data_cnt == `BYTE_LAST);
    assign wr_fire = byte_done && !instr.is_read;
    assign next_addr = step_addr(addr, lsb_first);

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= serial_config_port_pkg::ST_IDLE;
            instr <= '0;
            instr_sr <= 16'h0000;
            instr_cnt <= 4'h0;
            rx_sr <= 8'h00;
            data_cnt <= 3'h0;
            bytes_left <= 2'h0;
            streaming <= 1'b0;
            tx_byte <= 8'h00;
            addr <= 13'h0000;
        end else if (cs_rise && !two_wire_in) begin
            // mid-byte deselect, or end of a stream, drops the frame
            if ((state == serial_config_port_pkg::ST_INSTR && instr_cnt[2:0] != 3'h0) ||
                (state == serial_config_port_pkg::ST_DATA && (data_cnt != 3'h0 || streaming))) begin
                state <= serial_config_port_pkg::ST_IDLE;
                data_cnt <= 3'h0;
                instr_cnt <= 4'h0;
                streaming <= 1'b0;
            end
            // deselect on a byte boundary keeps the frame position
        end else if (active_rise) begin
            case (state)
                serial_config_port_pkg::ST_IDLE: begin
                    instr_sr <= next_instr;
                    instr_cnt <= 4'h1;
                    state <= serial_config_port_pkg::ST_INSTR;
                end
                serial_config_port_pkg::ST_INSTR: begin
                    instr_sr <= next_instr;
                    instr_cnt <= instr_cnt + 4'h1;
                    if (instr_cnt == `INSTR_LAST) begin
                        instr <= serial_config_port_pkg::instr_t'(next_instr);
                        addr <= next_instr[12:0];
                        bytes_left <= next_instr[14:13];
                        streaming <= (next_instr[14:13] == `LEN_STREAM);
                        tx_byte <= shadow_mem[next_instr[7:0]];
                        data_cnt <= 3'h0;
                        state <= serial_config_port_pkg::ST_DATA;
                    end
                end
                serial_config_port_pkg::ST_DATA: begin
                    rx_sr <= next_byte;
                    data_cnt <= data_cnt + 3'h1;
                    if (data_cnt == `BYTE_LAST) begin
                        addr <= next_addr;
                        tx_byte <= shadow_mem[next_addr[7:0]];
                        if (!streaming && bytes_left == 2'h0) begin
                            state <= serial_config_port_pkg::ST_IDLE;
                        end else if (!streaming) begin
                            bytes_left <= bytes_left - 2'h1;
                        end
                    end
                end
                default: begin
                    state <= serial_config_port_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // readback driver
    logic [2:0] tx_idx;
    assign tx_idx = lsb_first ? data_cnt : 3'h7 - data_cnt;

    // release on deselect or on the rise that ends the frame
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sdio_out <= 1'b0;
            sdio_oe_out <= 1'b0;
        end else if ((cs_rise && !two_wire_in) || state != serial_config_port_pkg::ST_DATA || !instr.is_read) begin
            sdio_oe_out <= 1'b0;
            sdio_out <= 1'b0;
        end else if ((sclk_fall || !sclk_st) && sel_low) begin
            // a stall leaves the clock low, so the resumed byte is driven without a fresh fall
            sdio_oe_out <= 1'b1;
            sdio_out <= tx_byte[tx_idx];
        end
    end

    // ==========================================
    // register writes and transfer
    // shadow holds what the host wrote; readback returns it before a transfer
    always_ff @(posedge ref_clk_in) begin
        if (wr_fire) begin
            shadow_mem[addr[7:0]] <= next_byte;
        end
    end

    logic xfer_go;
    logic unbuffered;
    assign unbuffered = (addr[7:0] == `CFG_ADDR) || (addr[7:0] == `UNBUF_ADDR_A) ||
        (addr[7:0] == `UNBUF_ADDR_B);
    assign xfer_go = wr_fire && (addr[7:0] == `XFER_ADDR) && next_byte[`XFER_GO_BIT];

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                active_mem[i] <= `REG_RESET;
            end
        end else if (xfer_go) begin
            for (int i = 0; i < `REG_COUNT; i++) begin
                active_mem[i] <= shadow_mem[i];
            end
            // transfer bit clears itself once applied
            active_mem[`XFER_ADDR] <= `REG_RESET;
        end else if (wr_fire && unbuffered) begin
            active_mem[addr[7:0]] <= next_byte;
        end
    end

    // ==========================================
    // status outputs
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            xfer_done_out <= 1'b0;
            lsb_first_out <= 1'b0;
            frame_active_out <= 1'b0;
            cfg_data_out <= 8'h00;
        end else begin
            xfer_done_out <= xfer_go;
            lsb_first_out <= lsb_first;
            frame_active_out <= (state != serial_config_port_pkg::ST_IDLE);
            cfg_data_out <= active_mem[cfg_addr_in];
        end
    end
endmodule : serial_config_port

/* test/scp_host.sv */
`timescale 1ns/1ps
// ========
// host side of the three-wire port
module scp_host (
    input wire logic clk_in, // bench clock
    input wire logic sdio_in, // resolved data line
    output logic sclk_out, // serial clock
    output logic cs_n_out, // select, active low
    output logic sdio_out, // host data
    output logic sdio_oe_out // host drives data
);
    // select low at strap time keeps the serial role
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b0;
        sdio_out = 1'b0;
        sdio_oe_out = 1'b0;
    end
    task automatic pins(input logic c, input logic k, input logic d, input logic e);
        cs_n_out = c;
        sclk_out = k;
        sdio_out = d;
        sdio_oe_out = e;
    endtask : pins
    // 80 ns bit; data moves while the clock is low, so it is settled at the rise
    task automatic shift(input logic [31:0] tx, input int n, input logic drv, output logic [31:0] rx);
        rx = '0;
        sdio_oe_out = drv;
        for (int i = n - 1; i >= 0; i--) begin
            sclk_out = 1'b0;
            sdio_out = tx[i];
            repeat (5) @(negedge clk_in);
            rx[i] = sdio_in;
            sclk_out = 1'b1;
            repeat (5) @(negedge clk_in);
        end
        sclk_out = 1'b0;
    endtask : shift
endmodule : scp_host

/* test/scp_properties.sv */
`timescale 1ns/1ps
// ========
// port checks
module scp_checker (
    input wire logic ref_clk_in, // clock
    input wire logic rst_in, // reset
    input wire logic sclk_in, // serial clock
    input wire logic cs_n_in, // select
    input wire logic two_wire_in, // 2-wire
    input wire logic sdio_out, // data out
    input wire logic sdio_oe_out, // data drive
    input wire logic secondary_mode_out, // strap
    input wire logic alt_sclk_out, // alt clock
    input wire logic alt_sdio_out, // alt data
    input wire logic lsb_first_out, // order
    input wire logic frame_active_out, // busy
    input wire logic xfer_done_out // apply pulse
);
    logic [3:0] hi_cnt;
    default clocking @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);
    // pin synchronisers delay a select rise by a few clocks
    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            hi_cnt <= 4'h0;
        end else if (!cs_n_in) begin
            hi_cnt <= 4'h0;
        end else if (hi_cnt != 4'hf) begin
            hi_cnt <= hi_cnt + 4'h1;
        end
    end
    sel_rise_a: assert property ($rose(cs_n_in) && !two_wire_in |-> ##[1:6] !sdio_oe_out)
        else $error("data pin driven after select rise");
    idle_high_a: assert property (hi_cnt > 4'h8 && !two_wire_in |-> !sdio_oe_out && !$rose(frame_active_out))
        else $error("activity while deselected");
    strap_quiet_a: assert property (secondary_mode_out |-> !frame_active_out && !sdio_oe_out)
        else $error("serial activity in secondary role");
    alt_idle_a: assert property (!secondary_mode_out |-> !alt_sclk_out && !alt_sdio_out)
        else $error("alternate pins active in serial role");
    two_wire_a: assert property (two_wire_in |-> !secondary_mode_out)
        else $error("secondary role in 2-wire mode");
    apply_pulse_a: assert property (xfer_done_out |=> !xfer_done_out)
        else $error("apply pulse too long");
    read_turn_a: assert property ($rose(sdio_oe_out) |-> frame_active_out && !$past(sclk_in, 2))
        else $error("turnaround outside a falling edge");
    fall_launch_a: assert property (sdio_oe_out && $changed(sdio_out) |-> !$past(sclk_in, 2))
        else $error("read bit changed away from a falling edge");
    order_strap_a: assert property ($rose(lsb_first_out) |-> !secondary_mode_out)
        else $error("bit order changed in secondary role");
    cover property (xfer_done_out);
    cover property ($rose(sdio_oe_out));
    cover property (secondary_mode_out);
endmodule : scp_checker
bind serial_config_port scp_checker u_chk (.ref_clk_in, .rst_in, .sclk_in, .cs_n_in, .two_wire_in, .sdio_out,
    .sdio_oe_out, .secondary_mode_out, .alt_sclk_out, .alt_sdio_out, .lsb_first_out, .frame_active_out,
    .xfer_done_out);

/* test/tb.sv */
`timescale 1ns/1ps
`define CHECK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("Error %0t: got %h expected %h", $time, g, e); end end
module tb;
    logic ref_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic two_wire_in = 1'b0;
    logic [7:0] cfg_addr_in = 8'h00;
    logic sclk, cs_n, h_sdio, h_oe, d_sdio, d_oe, line, sec, asclk, asdio, lsb, act, done, lsb_mode;
    logic [7:0] cfg;
    logic [31:0] rx;
    int fails = 0;
    int n_checks = 0;
    int n_done = 0;
    always #4 ref_clk_in = ~ref_clk_in;
    // released line falls to the pin's pull-down
    assign line = d_oe ? d_sdio : (h_oe ? h_sdio : 1'b0);
    always @(posedge ref_clk_in) if (done === 1'b1) n_done++;
    serial_config_port dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .sdio_in(line), .two_wire_in(two_wire_in), .cfg_addr_in(cfg_addr_in), .sdio_out(d_sdio),
        .sdio_oe_out(d_oe), .secondary_mode_out(sec), .alt_sclk_out(asclk), .alt_sdio_out(asdio),
        .lsb_first_out(lsb), .frame_active_out(act), .xfer_done_out(done), .cfg_data_out(cfg));
    scp_host host (.clk_in(ref_clk_in), .sdio_in(line), .sclk_out(sclk), .cs_n_out(cs_n),
        .sdio_out(h_sdio), .sdio_oe_out(h_oe));
    function automatic logic [31:0] flip(input logic [31:0] v, input int g);
        logic [31:0] r;
        for (int i = 0; i < 32; i++)
            r[i] = v[(i / g) * g + g - 1 - i % g];
        return r;
    endfunction : flip
    // ========
    // access tasks
    task automatic frame(input logic [15:0] ins, input int nb, input logic [31:0] wd, input logic stall);
        logic [31:0] r;
        logic [31:0] d;
        rx = '0;
        d = lsb_mode ? flip(wd, 8) : wd;
        host.pins(1'b0, 1'b0, 1'b0, 1'b0);
        host.shift(lsb_mode ? flip({16'h0, ins}, 16) : {16'h0, ins}, 16, 1'b1, r);
        for (int b = nb - 1; b >= 0; b--) begin
            host.shift(d >> (8 * b), 8, !ins[15], r);
            r = lsb_mode ? flip(r, 8) : r;
            rx[8 * b +: 8] = r[7:0];
            if (stall && b > 0) begin
                host.pins(1'b1, 1'b0, 1'b0, 1'b0);
                repeat (12) @(negedge ref_clk_in);
                host.pins(1'b0, 1'b0, 1'b0, 1'b0);
            end
        end
        host.pins(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (12) @(negedge ref_clk_in);
    endtask : frame
    task automatic peek(input logic [7:0] a, input logic [7:0] e);
        cfg_addr_in = a;
        repeat (2) @(negedge ref_clk_in);
        `CHECK(cfg, e)
    endtask : peek
    task automatic restart(input logic c, input logic tw);
        rst_in = 1'b1;
        two_wire_in = tw;
        lsb_mode = 1'b0;
        host.pins(c, 1'b0, 1'b0, 1'b0);
        repeat (3) @(negedge ref_clk_in);
        rst_in = 1'b0;
        repeat (20) @(negedge ref_clk_in);
    endtask : restart
    task automatic print_verdict();
        if (fails == 0 && n_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : print_verdict
    // ========
    // tests
    initial begin
        restart(1'b0, 1'b0);
        `CHECK({sec, lsb, act, done, d_oe}, 5'h00)
        frame(16'h0010, 1, 32'ha5, 1'b0);
        peek(8'h10, 8'h00);
        frame(16'h8010, 1, 32'h0, 1'b0);
        `CHECK(rx[7:0], 8'ha5)
        frame(16'h00ff, 1, 32'h01, 1'b0);
        `CHECK(n_done, 1)
        peek(8'h10, 8'ha5);
        frame(16'h0004, 1, 32'h3c, 1'b0);
        peek(8'h04, 8'h3c);
        frame(16'h4022, 3, 32'h11a2b3, 1'b1);
        frame(16'hc022, 3, 32'h0, 1'b1);
        `CHECK(rx[23:0], 24'h11a2b3)
        host.pins(1'b0, 1'b0, 1'b0, 1'b1);
        host.shift(32'h0030, 16, 1'b1, rx);
        host.shift(32'ha, 4, 1'b1, rx);
        host.pins(1'b1, 1'b0, 1'b0, 1'b0);
        repeat (12) @(negedge ref_clk_in);
        `CHECK(act, 1'b0)
        host.shift(32'hffff, 16, 1'b1, rx);
        `CHECK(act, 1'b0)
        frame(16'h8030, 1, 32'h0, 1'b0);
        `CHECK(rx[7:0], 8'h00)
        frame(16'h6043, 4, 32'h01020304, 1'b0);
        frame(16'he043, 4, 32'h0, 1'b0);
        `CHECK(rx, 32'h01020304)
        frame(16'h0000, 1, 32'h40, 1'b0);
        `CHECK(lsb, 1'b1)
        lsb_mode = 1'b1;
        frame(16'h2050, 2, 32'hc381, 1'b0);
        frame(16'ha050, 2, 32'h0, 1'b0);
        `CHECK(rx[15:0], 16'hc381)
        restart(1'b1, 1'b0);
        `CHECK(sec, 1'b1)
        host.pins(1'b1, 1'b1, 1'b1, 1'b1);
        repeat (8) @(negedge ref_clk_in);
        `CHECK({asclk, asdio}, 2'b11)
        restart(1'b1, 1'b1);
        `CHECK(sec, 1'b0)
        // whole frames only: 2-wire framing cannot recover from a slip
        host.shift(32'h0005, 16, 1'b1, rx);
        host.shift(32'h5a, 8, 1'b1, rx);
        repeat (12) @(negedge ref_clk_in);
        peek(8'h05, 8'h5a);
        print_verdict();
    end
    initial begin
        #400000;
        fails++;
        print_verdict();
    end
endmodule : tb
